// >>> verilog/sps_pkg.sv
// package for the status pin and reset logic: timing, carriers, states
// assumes a single 100 MHz system clock shared by every user
package sps_pkg;

   localparam longint unsigned CLK_HZ       = 100_000_000;
   localparam longint unsigned MS_PER_S     = 1_000;
   localparam longint unsigned NS_PER_S     = 1_000_000_000;

   // press windows of the factory-restore button, in milliseconds
   localparam longint unsigned RESTART_MIN_MS = 200;
   localparam longint unsigned RESTART_MAX_MS = 800;
   localparam longint unsigned RESTORE_MIN_MS = 5_000;
   localparam longint unsigned RESTORE_MAX_MS = 10_000;
   // lamp timing: 10 Hz square wave, link blink half period
   localparam longint unsigned ACT_HALF_MS    = 50;
   localparam longint unsigned LINK_HALF_MS   = 250;
   // shortest accepted external reset, in nanoseconds
   localparam longint unsigned EXT_RST_MIN_NS = 100;

   // least times round up, longest times round down
   localparam longint unsigned RESTART_MIN_CYC =
      (RESTART_MIN_MS * CLK_HZ + MS_PER_S - 1) / MS_PER_S;
   localparam longint unsigned RESTART_MAX_CYC =
      (RESTART_MAX_MS * CLK_HZ) / MS_PER_S;
   localparam longint unsigned RESTORE_MIN_CYC =
      (RESTORE_MIN_MS * CLK_HZ + MS_PER_S - 1) / MS_PER_S;
   localparam longint unsigned RESTORE_MAX_CYC =
      (RESTORE_MAX_MS * CLK_HZ) / MS_PER_S;
   localparam longint unsigned ACT_HALF_CYC =
      (ACT_HALF_MS * CLK_HZ) / MS_PER_S;
   localparam longint unsigned LINK_HALF_CYC =
      (LINK_HALF_MS * CLK_HZ) / MS_PER_S;
   localparam longint unsigned EXT_RST_MIN_CYC =
      (EXT_RST_MIN_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S;

   // reset levels
   localparam logic LAMP_ACT_RST  = 1'h1;
   localparam logic LAMP_LINK_RST = 1'h0;

   typedef struct packed {
      logic cable_present;
      logic link_up;
      logic tx_busy;
      logic rx_busy;
   } sps_net_type;

   typedef enum logic {
      PRESS_IDLE,
      PRESS_HELD
   } sps_press_type;

endpackage

// >>> verilog/sps_blinker.sv
// lamp driver: square wave while running, a steady level otherwise
// assumes i_idle and i_run are synchronous to i_clk
`timescale 1ns/1ns
module sps_blinker #(
   parameter int   HALF_CYC = int'(sps_pkg::ACT_HALF_CYC),
   parameter logic RST_LVL  = sps_pkg::LAMP_ACT_RST
) (
   input  wire logic i_clk,
   input  wire logic i_sys_rst,
   input  wire logic i_run,
   input  wire logic i_idle,
   output logic      o_lamp
);
   import sps_pkg::*;

   localparam int CW = $clog2(HALF_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic          lamp_reg;
   logic          lamp_next;

   always_comb begin
      cnt_next  = '0;
      lamp_next = i_idle;
      if (i_run) begin
         // first edge lands one half period after start, from idle level
         lamp_next = lamp_reg;
         cnt_next  = cnt_reg + CW'(1);
         if (cnt_reg == LAST) begin
            cnt_next  = '0;
            lamp_next = ~lamp_reg;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt_reg  <= '0;
         lamp_reg <= RST_LVL;
      end else begin
         cnt_reg  <= cnt_next;
         lamp_reg <= lamp_next;
      end
   end

   assign o_lamp = lamp_reg;
endmodule // sps_blinker

// >>> verilog/sps_status_pins.sv
// status lamps, restore button decoder, external reset and direction pin
// assumes all inputs synchronous to i_clk; button and reset are active low
//
// Behaviour
// - a low on the restore button held about 5 to 10 s restores defaults.
// - a low held about 200 to 800 ms restarts without restoring defaults.
// - the transmit lamp rests high and toggles at 10 Hz while sending.
// - the receive lamp rests high and toggles at 10 Hz while receiving.
// - the port is full duplex unless a transceiver strap sets direction mode.
// - in direction mode the pin is high while sending and low otherwise.
`timescale 1ns/1ns
module sps_status_pins #(
   parameter int RESTART_MIN = int'(sps_pkg::RESTART_MIN_CYC),
   parameter int RESTART_MAX = int'(sps_pkg::RESTART_MAX_CYC),
   parameter int RESTORE_MIN = int'(sps_pkg::RESTORE_MIN_CYC),
   parameter int RESTORE_MAX = int'(sps_pkg::RESTORE_MAX_CYC),
   parameter int ACT_HALF    = int'(sps_pkg::ACT_HALF_CYC),
   parameter int LINK_HALF   = int'(sps_pkg::LINK_HALF_CYC),
   parameter int EXT_RST_MIN = int'(sps_pkg::EXT_RST_MIN_CYC)
) (
   input  wire logic                i_clk,
   input  wire logic                i_sys_rst,
   input  wire logic                i_restore_n,
   input  wire logic                i_ext_rst_n,
   input  wire logic                i_xcvr_strap,
   input  wire sps_pkg::sps_net_type i_net,
   output logic                     o_restart,
   output logic                     o_restore_defaults,
   output logic                     o_ext_reset,
   output logic                     o_link_lamp,
   output logic                     o_transmit_activity_lamp,
   output logic                     o_receive_activity_lamp,
   output logic                     o_dir,
   output logic                     o_dir_oe
);
   import sps_pkg::*;

   localparam int CNT_W = $clog2(RESTORE_MAX + 2);
   localparam logic [CNT_W-1:0] RS_MIN  = CNT_W'(RESTART_MIN);
   localparam logic [CNT_W-1:0] RS_MAX  = CNT_W'(RESTART_MAX);
   localparam logic [CNT_W-1:0] RD_MIN  = CNT_W'(RESTORE_MIN);
   localparam logic [CNT_W-1:0] RD_MAX  = CNT_W'(RESTORE_MAX);
   localparam logic [CNT_W-1:0] CNT_SAT = CNT_W'(RESTORE_MAX + 1);
   localparam int EXT_W = $clog2(EXT_RST_MIN + 1);
   localparam logic [EXT_W-1:0] EXT_LAST = EXT_W'(EXT_RST_MIN - 1);
   localparam logic [EXT_W-1:0] EXT_SAT  = EXT_W'(EXT_RST_MIN);

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   // ---------------- restore button decoder
   sps_press_type    press_reg;
   sps_press_type    press_next;
   logic [CNT_W-1:0] hold_reg;
   logic [CNT_W-1:0] hold_next;
   logic             restart_reg;
   logic             restart_next;
   logic             restore_reg;
   logic             restore_next;

   always_comb begin
      press_next   = press_reg;
      hold_next    = hold_reg;
      restart_next = 1'h0;
      restore_next = 1'h0;
      unique case (press_reg)
         PRESS_IDLE: begin
            if (!i_restore_n) begin
               press_next = PRESS_HELD;
               hold_next  = CNT_W'(1);
            end
         end
         PRESS_HELD: begin
            if (i_restore_n) begin
               // judged on release only; counter saturates past the window
               press_next = PRESS_IDLE;
               hold_next  = '0;
               if (hold_reg >= RS_MIN && hold_reg <= RS_MAX) begin
                  restart_next = 1'h1;
               end else if (hold_reg >= RD_MIN && hold_reg <= RD_MAX) begin
                  restore_next = 1'h1;
               end
            end else if (hold_reg != CNT_SAT) begin
               hold_next = hold_reg + CNT_W'(1);
            end
         end
      endcase
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         press_reg   <= PRESS_IDLE;
         hold_reg    <= '0;
         restart_reg <= 1'h0;
         restore_reg <= 1'h0;
      end else begin
         press_reg   <= press_next;
         hold_reg    <= hold_next;
         restart_reg <= restart_next;
         restore_reg <= restore_next;
      end
   end

   assign o_restart          = restart_reg;
   assign o_restore_defaults = restore_reg;

   a_restore_window: assert property (
      o_restore_defaults |-> $past(press_reg == PRESS_HELD && i_restore_n
         && hold_reg >= RD_MIN && hold_reg <= RD_MAX))
      else $error("restore pulse outside the long press window");

   a_restart_window: assert property (
      o_restart |-> $past(press_reg == PRESS_HELD && i_restore_n
         && hold_reg >= RS_MIN && hold_reg <= RS_MAX))
      else $error("restart pulse outside the short press window");

   a_action_release: assert property (
      (press_reg == PRESS_HELD && !i_restore_n) |=>
         !o_restart && !o_restore_defaults)
      else $error("press action taken before release");

   c_restart: cover property (o_restart);
   c_restore: cover property (o_restore_defaults);

   // ---------------- external reset qualifier
   logic [EXT_W-1:0] ext_cnt_reg;
   logic [EXT_W-1:0] ext_cnt_next;
   logic             ext_rst_reg;
   logic             ext_rst_next;

   always_comb begin
      ext_cnt_next = '0;
      ext_rst_next = 1'h0;
      if (!i_ext_rst_n) begin
         // one pulse per low period, once it has lasted long enough
         ext_cnt_next = (ext_cnt_reg == EXT_SAT) ? ext_cnt_reg
                                                 : ext_cnt_reg + EXT_W'(1);
         ext_rst_next = (ext_cnt_reg == EXT_LAST);
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ext_cnt_reg <= '0;
         ext_rst_reg <= 1'h0;
      end else begin
         ext_cnt_reg <= ext_cnt_next;
         ext_rst_reg <= ext_rst_next;
      end
   end

   assign o_ext_reset = ext_rst_reg;

   // ---------------- direction pin and its strap
   logic strap_taken_reg;
   logic strap_taken_next;
   logic strap_reg;
   logic strap_next;
   logic dir_reg;
   logic dir_next;
   logic dir_oe_reg;
   logic dir_oe_next;

   always_comb begin
      strap_taken_next = 1'h1;
      // strap sampled once, on the first edge after reset release
      strap_next  = strap_taken_reg ? strap_reg : i_xcvr_strap;
      dir_oe_next = strap_next;
      dir_next    = strap_next & i_net.tx_busy;
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         strap_taken_reg <= 1'h0;
         strap_reg       <= 1'h0;
         dir_reg         <= 1'h0;
         dir_oe_reg      <= 1'h0;
      end else begin
         strap_taken_reg <= strap_taken_next;
         strap_reg       <= strap_next;
         dir_reg         <= dir_next;
         dir_oe_reg      <= dir_oe_next;
      end
   end

   assign o_dir    = dir_reg;
   assign o_dir_oe = dir_oe_reg;

   a_dir_duplex: assert property (
      (strap_taken_reg && !strap_reg) |-> !o_dir && !o_dir_oe)
      else $error("direction pin active in full duplex mode");

   a_dir_follow: assert property (
      (strap_reg && $past(strap_reg)) |-> o_dir == $past(i_net.tx_busy))
      else $error("direction pin does not track transmit");

   // ---------------- lamps
   sps_blinker #(
      .HALF_CYC (LINK_HALF),
      .RST_LVL  (LAMP_LINK_RST)
   ) u_link (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_run     (i_net.cable_present & ~i_net.link_up),
      .i_idle    (i_net.cable_present & i_net.link_up),
      .o_lamp    (o_link_lamp)
   );

   sps_blinker #(
      .HALF_CYC (ACT_HALF),
      .RST_LVL  (LAMP_ACT_RST)
   ) u_tx (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_run     (i_net.tx_busy),
      .i_idle    (1'h1),
      .o_lamp    (o_transmit_activity_lamp)
   );

   sps_blinker #(
      .HALF_CYC (ACT_HALF),
      .RST_LVL  (LAMP_ACT_RST)
   ) u_rx (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_run     (i_net.rx_busy),
      .i_idle    (1'h1),
      .o_lamp    (o_receive_activity_lamp)
   );

   a_link_dark: assert property (
      !i_net.cable_present |=> !o_link_lamp)
      else $error("link lamp lit without cable");

   a_link_steady: assert property (
      (i_net.cable_present && i_net.link_up) |=> o_link_lamp)
      else $error("link lamp not steady with link up");

   a_tx_rest: assert property (
      !i_net.tx_busy |=> o_transmit_activity_lamp)
      else $error("transmit lamp not resting high");

   a_tx_toggle: assert property (
      $fell(o_transmit_activity_lamp) |-> $past(i_net.tx_busy))
      else $error("transmit lamp dropped while idle");

   a_rx_rest: assert property (
      !i_net.rx_busy |=> o_receive_activity_lamp)
      else $error("receive lamp not resting high");

   a_rx_toggle: assert property (
      $fell(o_receive_activity_lamp) |-> $past(i_net.rx_busy))
      else $error("receive lamp dropped while idle");

   c_link_blink: cover property (
      i_net.cable_present && !i_net.link_up && $fell(o_link_lamp));
   c_tx_blink: cover property ($fell(o_transmit_activity_lamp));
endmodule // sps_status_pins

// >>> tb/sps_host_model.sv
// host side model: restore button and external reset pin, both pulled up
// assumes the bench strobes i_go for one cycle and waits for o_busy low
`timescale 1ns/1ns
module sps_host_model (
   input  wire logic        i_clk,
   input  wire logic        i_go,
   input  wire logic        i_sel,
   input  wire logic [31:0] i_len,
   output logic             o_restore_n,
   output logic             o_ext_rst_n,
   output logic             o_busy
);
   int   cnt  = 0;
   logic sel  = 1'h0;
   logic busy = 1'h0;
   assign o_busy = busy;
   // released pins return to the pull-up level
   assign o_restore_n = !(busy && !sel);
   // low for exactly i_len sampled edges
   assign o_ext_rst_n = !(busy && sel);
   always @(posedge i_clk) begin
      if (busy) begin
         if (cnt == 1) busy <= 1'h0;
         cnt <= cnt - 1;
      end else if (i_go) begin
         busy <= 1'h1;
         cnt <= i_len;
         sel <= i_sel;
      end
   end
endmodule // sps_host_model

// >>> tb/status_pin_and_reset_logic_bench.sv
// bench for the status pins: button windows, external reset, lamps, dir
// assumes shortened press and lamp counts set at the instance below
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
 $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module status_pin_and_reset_logic_bench;
   import sps_pkg::*;
   localparam int AH = 5;
   localparam int LH = 7;
   logic        clk = 1'h0, rst = 1'h1, strap = 1'h1, go = 1'h0, sel = 1'h0;
   sps_net_type net = 4'h0;
   int          len = 0, n_mismatch = 0, checks = 0, nr = 0, nd = 0, ne = 0;
   wire logic   rn, en, busy, rs, rd, ex, lk, txl, rxl, dir, oe;
   always #5 clk = ~clk;
   always @(posedge clk) begin
      nr += int'(rs);
      nd += int'(rd);
      ne += int'(ex);
   end
   sps_host_model host (.i_clk(clk), .i_go(go), .i_sel(sel), .i_len(len),
      .o_restore_n(rn), .o_ext_rst_n(en), .o_busy(busy));
   sps_status_pins #(.RESTART_MIN(20), .RESTART_MAX(80), .RESTORE_MIN(500),
      .RESTORE_MAX(1000), .ACT_HALF(AH), .LINK_HALF(LH), .EXT_RST_MIN(10))
   uut (.i_clk(clk), .i_sys_rst(rst), .i_restore_n(rn), .i_ext_rst_n(en),
      .i_xcvr_strap(strap), .i_net(net), .o_restart(rs),
      .o_restore_defaults(rd), .o_ext_reset(ex), .o_link_lamp(lk),
      .o_transmit_activity_lamp(txl), .o_receive_activity_lamp(rxl),
      .o_dir(dir), .o_dir_oe(oe));
   function automatic logic lamp(int k);
      return (k == 0) ? txl : ((k == 1) ? rxl : lk);
   endfunction
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // one press of n low samples; counts pulses of each kind afterwards
   task automatic press(int n, logic sl, int er, int ed, int ee);
      int r0, d0, e0, t;
      r0 = nr;
      d0 = nd;
      e0 = ne;
      t = 0;
      @(posedge clk) begin go <= 1'h1; sel <= sl; len <= n; end
      @(posedge clk) go <= 1'h0;
      #1;
      while (busy && t < 2000) begin cyc(1); t++; end
      if (t >= 2000) begin n_mismatch++; end_sim(); end
      cyc(4);
      `CHK("restart", er, nr - r0)
      `CHK("restore", ed, nd - d0)
      `CHK("ext_reset", ee, ne - e0)
      $display("done press %0d sel %0d", n, sl);
   endtask
   // gaps between lamp edges must all equal half
   task automatic blink(int k, int half, int n);
      logic p, c;
      int   last, t, tg;
      last = -1;
      tg = 0;
      // step off the edge that launched the new inputs
      #1;
      p = lamp(k);
      for (t = 0; t < n; t++) begin
         cyc(1);
         c = lamp(k);
         if (c !== p) begin
            if (last >= 0) `CHK("half", half, t - last)
            tg++;
            last = t;
         end
         p = c;
      end
      `CHK("blinks", 1'h1, tg > 2)
   endtask
   task automatic act(int k);
      `CHK("lamp_rest", 1'h1, lamp(k))
      @(posedge clk) net <= (k == 0) ? 4'h2 : 4'h1;
      blink(k, AH, 8 * AH);
      @(posedge clk) net <= 4'h0;
      cyc(2);
      `CHK("lamp_rest", 1'h1, lamp(k))
      $display("done activity lamp %0d", k);
   endtask
   task automatic link_t;
      cyc(2);
      `CHK("link_off", 1'h0, lk)
      @(posedge clk) net <= 4'hC;
      cyc(2);
      `CHK("link_on", 1'h1, lk)
      @(posedge clk) net <= 4'h8;
      blink(2, LH, 6 * LH);
      @(posedge clk) net <= 4'h0;
      $display("done link lamp");
   endtask
   task automatic dir_t;
      @(posedge clk) net <= 4'h2;
      cyc(2);
      `CHK("dir_high", 1'h1, dir)
      `CHK("dir_oe", 1'h1, oe)
      @(posedge clk) net <= 4'h0;
      cyc(2);
      `CHK("dir_low", 1'h0, dir)
      // strap is only taken after reset, so reset again without it
      @(posedge clk) begin strap <= 1'h0; rst <= 1'h1; end
      @(posedge clk) rst <= 1'h0;
      cyc(3);
      @(posedge clk) net <= 4'h2;
      cyc(2);
      `CHK("duplex_oe", 1'h0, oe)
      `CHK("duplex_dir", 1'h0, dir)
      @(posedge clk) net <= 4'h0;
      $display("done direction pin");
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'h0;
      cyc(3);
      press(19, 1'h0, 0, 0, 0);
      press(20, 1'h0, 1, 0, 0);
      press(80, 1'h0, 1, 0, 0);
      press(81, 1'h0, 0, 0, 0);
      press(499, 1'h0, 0, 0, 0);
      press(500, 1'h0, 0, 1, 0);
      press(1000, 1'h0, 0, 1, 0);
      press(1001, 1'h0, 0, 0, 0);
      press(9, 1'h1, 0, 0, 0);
      press(10, 1'h1, 0, 0, 1);
      press(30, 1'h1, 0, 0, 1);
      act(0);
      act(1);
      link_t();
      dir_t();
      end_sim();
   end
endmodule // status_pin_and_reset_logic_bench
